// [verilog/rss_reset_sequencer.sv]
// reset source sequencer: power-on, power-fail, software and flash-error resets
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module rss_reset_sequencer
   import rss_pkg::*;
#(
   parameter int POR_DELAY = POR_DELAY_CYC
) (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // supply comparators and core events
   input  wire rss_supply_type supply,
   input  wire logic        sleep_mode,
   input  wire logic        flash_op_req,
   // reset pin, open drain
   output logic             rst_pin_o,
   output logic             rst_pin_oe,
   // core control and warning interrupt
   output rss_core_type     core,
   output logic             warn_irq
);

   rss_state_type         state_r, state_nxt;
   logic [POR_CNT_W-1:0]  cnt_r, cnt_nxt;
   logic                  mon_en_r, mon_sel_r, warn_ie_r, bat_dis_r;
   logic                  por_flag_r, soft_flag_r, flash_flag_r;
   logic [31:0]           prdata_r;

   // apb decode
   wire setup_rd  = psel & ~penable & ~pwrite;
   wire wr_acc    = psel & penable & pwrite & (state_r == ST_RUN);
   wire sel_ctrl  = (paddr == SUPPLY_MONITOR_CTRL_OFS);
   wire sel_cause = (paddr == RESET_CAUSE_REG_OFS);
   wire sel_pmu   = (paddr == POWER_UNIT_MODE_REG_OFS);
   wire sel_stat  = (paddr == SEQ_STATUS_OFS);
   wire mapped    = sel_ctrl | sel_cause | sel_pmu | sel_stat;
   wire wr_ctrl   = wr_acc & sel_ctrl;
   wire wr_cause  = wr_acc & sel_cause;
   wire wr_pmu    = wr_acc & sel_pmu;

   // reset triggers while running
   wire run       = (state_r == ST_RUN);
   wire pf_armed  = mon_en_r & mon_sel_r & ~sleep_mode;
   wire pf_trip   = pf_armed & ~supply.main_above_rst;
   wire soft_trip = wr_cause & pwdata[SOFT_RST_BIT];
   wire flash_trip = flash_op_req & ~mon_en_r;
   wire any_trip  = run & (pf_trip | soft_trip | flash_trip);
   wire delay_done = (cnt_r == POR_CNT_W'(POR_DELAY - 1));

   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = '0;
      case (state_r)
         ST_POR_WAIT: begin
            if (supply.battery_above_por) state_nxt = ST_POR_DELAY;
         end
         ST_POR_DELAY: begin
            cnt_nxt = cnt_r + POR_CNT_W'(1);
            if (!supply.battery_above_por) state_nxt = ST_POR_WAIT;
            else if (delay_done) state_nxt = ST_RUN;
         end
         ST_PF_HOLD: begin
            if (supply.main_above_rst) state_nxt = ST_RUN;
         end
         ST_SOFT: state_nxt = ST_RUN;
         ST_RUN: begin
            if (any_trip && bat_dis_r) state_nxt = ST_POR_WAIT;
            else if (run && pf_trip) state_nxt = ST_PF_HOLD;
            else if (any_trip) state_nxt = ST_SOFT;
         end
         default: state_nxt = ST_POR_WAIT;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_POR_WAIT;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // entering a full power-on, a power-fail or a soft reset
   wire enter_full = run & (state_nxt == ST_POR_WAIT);
   wire enter_pf   = run & (state_nxt == ST_PF_HOLD);
   wire enter_soft = run & (state_nxt == ST_SOFT);

   // monitor enable and selection: only power-on and power-fail restore them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_en_r  <= MON_EN_RST;
         mon_sel_r <= MON_SEL_RST;
      end else if (enter_full || enter_pf) begin
         mon_en_r  <= MON_EN_RST;
         mon_sel_r <= MON_SEL_RST;
      end else begin
         if (wr_ctrl) mon_en_r <= pwdata[MON_EN_BIT];
         if (wr_cause) mon_sel_r <= pwdata[POR_FLAG_BIT];
      end
   end

   // ordinary registers reload on every reset entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warn_ie_r <= WARN_IE_RST;
         bat_dis_r <= BAT_DIS_RST;
      end else if (any_trip) begin
         warn_ie_r <= WARN_IE_RST;
         bat_dis_r <= BAT_DIS_RST;
      end else begin
         if (wr_ctrl) warn_ie_r <= pwdata[WARN_IE_BIT];
         if (wr_pmu) bat_dis_r <= pwdata[BAT_DIS_BIT];
      end
   end

   // reset cause flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_flag_r   <= 1'b1;
         soft_flag_r  <= 1'b0;
         flash_flag_r <= 1'b0;
      end else if (enter_full || enter_pf) begin
         por_flag_r   <= 1'b1;
      end else if (enter_soft) begin
         por_flag_r   <= 1'b0;
         soft_flag_r  <= soft_trip & ~flash_trip;
         flash_flag_r <= flash_trip;
      end
   end

   // read data, captured in the setup phase
   wire [31:0] rd_ctrl  = {24'h000000, mon_en_r, supply.main_above_rst,
                           supply.main_above_warn, 1'b0, warn_ie_r, 3'h0};
   wire [31:0] rd_cause = {25'h0000000, flash_flag_r, 1'b0, soft_flag_r,
                           2'h0, por_flag_r, 1'b0};
   wire [31:0] rd_pmu   = {26'h0000000, bat_dis_r, 5'h00};
   wire [31:0] rd_stat  = {27'h0000000, state_r};
   wire [31:0] rd_mux   = sel_ctrl  ? rd_ctrl  :
                          sel_cause ? rd_cause :
                          sel_pmu   ? rd_pmu   :
                          sel_stat  ? rd_stat  : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata_r <= 32'h00000000;
      else if (setup_rd) prdata_r <= rd_mux;
   end

   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // reset pin pulled low only by power-on and power-fail resets
   wire pin_low = (state_r == ST_POR_WAIT) | (state_r == ST_POR_DELAY) |
                  (state_r == ST_PF_HOLD);
   assign rst_pin_o  = 1'b0;
   assign rst_pin_oe = pin_low;

   // core controls; RAM has no reset path here, only the stack pointer
   assign core.core_reset      = ~run;
   assign core.periph_reset    = ~run;
   assign core.sp_reset        = ~run;
   assign core.fetch_addr      = RESET_VECTOR;
   assign core.clk_internal    = ~run;
   assign core.wdt_enable      = ~run;
   assign core.wdt_div         = WDT_DIV;
   assign core.port_latch      = PORT_LATCH_RST;
   assign core.port_open_drain = ~run;
   assign core.weak_pullup     = 1'b1;
   assign warn_irq = warn_ie_r & ~supply.main_above_warn & run;

   // checks
   sequence s_pf_enter;
      run && pf_trip && !bat_dis_r;
   endsequence
   sequence s_recover;
      (state_r == ST_PF_HOLD) && supply.main_above_rst;
   endsequence

   property p_pin_low;
      @(posedge pclk) disable iff (!presetn)
         (state_r != ST_RUN && state_r != ST_SOFT) |-> (rst_pin_oe && !rst_pin_o);
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("reset pin not low");

   property p_por_delay;
      @(posedge pclk) disable iff (!presetn)
         ($past(state_r) == ST_POR_DELAY && run) |-> ($past(cnt_r) == POR_DELAY - 1);
   endproperty
   a_por_delay: assert property (p_por_delay) else $error("release delay wrong");

   property p_pf_nodelay;
      @(posedge pclk) disable iff (!presetn)
         s_recover |=> run;
   endproperty
   a_pf_nodelay: assert property (p_pf_nodelay) else $error("pf release late");

   property p_pf_hold;
      @(posedge pclk) disable iff (!presetn)
         s_pf_enter |=> (state_r == ST_PF_HOLD) && mon_en_r && mon_sel_r && por_flag_r;
   endproperty
   a_pf_hold: assert property (p_pf_hold) else $error("power-fail entry wrong");

   property p_soft_flag;
      @(posedge pclk) disable iff (!presetn)
         (state_r == ST_SOFT) |-> !por_flag_r ##1 run;
   endproperty
   a_soft_flag: assert property (p_soft_flag) else $error("soft reset flag");

   property p_soft_keep;
      @(posedge pclk) disable iff (!presetn)
         (state_r == ST_SOFT) |-> ($stable(mon_en_r) && $stable(mon_sel_r));
   endproperty
   a_soft_keep: assert property (p_soft_keep) else $error("monitor lost");

   property p_sleep;
      @(posedge pclk) disable iff (!presetn)
         (run && sleep_mode && !soft_trip && !flash_trip) |=> run;
   endproperty
   a_sleep: assert property (p_sleep) else $error("reset in sleep");

   property p_flash;
      @(posedge pclk) disable iff (!presetn)
         (run && flash_op_req && !mon_en_r) |=> !run ##1 (state_r != ST_SOFT);
   endproperty
   a_flash: assert property (p_flash) else $error("flash error missed");

   property p_batdis;
      @(posedge pclk) disable iff (!presetn)
         (any_trip && bat_dis_r) |=> (state_r == ST_POR_WAIT) && !bat_dis_r;
   endproperty
   a_batdis: assert property (p_batdis) else $error("no full power-on");

   property p_run_exit;
      @(posedge pclk) disable iff (!presetn)
         $rose(run) |-> (core.fetch_addr == 16'h0000) && !core.clk_internal
                         && !core.core_reset;
   endproperty
   a_run_exit: assert property (p_run_exit) else $error("bad release");

   property p_core_hold;
      @(posedge pclk) disable iff (!presetn)
         !run |-> core.core_reset && core.periph_reset && core.sp_reset;
   endproperty
   a_core_hold: assert property (p_core_hold) else $error("core not held in reset");

   property p_ports;
      @(posedge pclk) disable iff (!presetn)
         !run |-> (core.port_latch == 8'hFF) && core.port_open_drain && core.weak_pullup;
   endproperty
   a_ports: assert property (p_ports) else $error("ports not at reset state");

   property p_pin_free;
      @(posedge pclk) disable iff (!presetn)
         (run || state_r == ST_SOFT) |-> !rst_pin_oe;
   endproperty
   a_pin_free: assert property (p_pin_free) else $error("reset pin driven");

   property p_wdt;
      @(posedge pclk) disable iff (!presetn)
         $rose(run) |-> $past(core.wdt_enable) && (core.wdt_div == 4'hC);
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog not set up");

   property p_por_hold;
      @(posedge pclk) disable iff (!presetn)
         (state_r == ST_POR_WAIT && !supply.battery_above_por)
            |=> (state_r == ST_POR_WAIT) && rst_pin_oe;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("power-up hold lost");

   property p_delay_step;
      @(posedge pclk) disable iff (!presetn)
         (state_r == ST_POR_DELAY && supply.battery_above_por && !delay_done)
            |=> (state_r == ST_POR_DELAY) && (cnt_r == $past(cnt_r) + POR_CNT_W'(1));
   endproperty
   a_delay_step: assert property (p_delay_step) else $error("delay count stalled");

   property p_full_flag;
      @(posedge pclk) disable iff (!presetn)
         (any_trip && bat_dis_r) |=> por_flag_r && mon_en_r && mon_sel_r;
   endproperty
   a_full_flag: assert property (p_full_flag) else $error("full power-on flag");

   property p_flash_cause;
      @(posedge pclk) disable iff (!presetn)
         (run && flash_trip && !bat_dis_r)
            |=> (state_r == ST_SOFT) && flash_flag_r && !por_flag_r;
   endproperty
   a_flash_cause: assert property (p_flash_cause) else $error("flash cause wrong");

   property p_warn_gate;
      @(posedge pclk) disable iff (!presetn)
         !warn_ie_r |-> !warn_irq;
   endproperty
   a_warn_gate: assert property (p_warn_gate) else $error("warning irq not gated");

   property p_warn_irq;
      @(posedge pclk) disable iff (!presetn)
         (run && warn_ie_r && !supply.main_above_warn) |-> warn_irq;
   endproperty
   a_warn_irq: assert property (p_warn_irq) else $error("warning irq missing");

   property p_sleep_keep;
      @(posedge pclk) disable iff (!presetn)
         (sleep_mode && !wr_ctrl && !wr_cause && !enter_full && !enter_pf)
            |=> $stable(mon_en_r) && $stable(mon_sel_r);
   endproperty
   a_sleep_keep: assert property (p_sleep_keep) else $error("monitor set lost in sleep");

   sequence s_pf_low;
      (state_r == ST_PF_HOLD) && !supply.main_above_rst;
   endsequence

   property p_pf_stay;
      @(posedge pclk) disable iff (!presetn)
         s_pf_low |=> (state_r == ST_PF_HOLD) && rst_pin_oe && core.core_reset;
   endproperty
   a_pf_stay: assert property (p_pf_stay) else $error("power-fail hold lost");

endmodule

// [verilog/rss_pkg.sv]
// constants, state codes and carriers of the reset source sequencer
package rss_pkg;
   // register byte offsets
   localparam logic [7:0] SUPPLY_MONITOR_CTRL_OFS = 8'h00;
   localparam logic [7:0] RESET_CAUSE_REG_OFS     = 8'h04;
   localparam logic [7:0] POWER_UNIT_MODE_REG_OFS = 8'h08;
   localparam logic [7:0] SEQ_STATUS_OFS          = 8'h0C;
   // supply_monitor_ctrl fields
   localparam int MON_EN_BIT     = 7;
   localparam int MAIN_STAT_BIT  = 6;
   localparam int WARN_OK_BIT    = 5;
   localparam int WARN_IE_BIT    = 3;
   // reset_cause_reg fields
   localparam int POR_FLAG_BIT   = 1;
   localparam int SOFT_RST_BIT   = 4;
   localparam int FLASH_ERR_BIT  = 6;
   // power_unit_mode_reg fields
   localparam int BAT_DIS_BIT    = 5;
   // reset values
   localparam logic       MON_EN_RST     = 1'b1;
   localparam logic       MON_SEL_RST    = 1'b1;
   localparam logic       WARN_IE_RST    = 1'b1;
   localparam logic       BAT_DIS_RST    = 1'b0;
   localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
   localparam logic [15:0] RESET_VECTOR  = 16'h0000;
   localparam logic [3:0] WDT_DIV        = 4'hC;
   // timing: power-on release delay, nominal figure
   localparam int CLK_MHZ          = 100;
   localparam int POR_DELAY_US     = 7000;
   localparam int POR_DELAY_CYC    = POR_DELAY_US * CLK_MHZ;
   localparam int POR_CNT_W        = 20;
   // sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_POR_WAIT  = 5'b00001,
      ST_POR_DELAY = 5'b00010,
      ST_PF_HOLD   = 5'b00100,
      ST_SOFT      = 5'b01000,
      ST_RUN       = 5'b10000
   } rss_state_type;
   // comparator levels from the analog monitors
   typedef struct packed {
      logic battery_above_por;
      logic main_above_rst;
      logic main_above_warn;
   } rss_supply_type;
   // controls towards the core and its peripherals
   typedef struct packed {
      logic        core_reset;
      logic        periph_reset;
      logic        sp_reset;
      logic [15:0] fetch_addr;
      logic        clk_internal;
      logic        wdt_enable;
      logic [3:0]  wdt_div;
      logic [7:0]  port_latch;
      logic        port_open_drain;
      logic        weak_pullup;
   } rss_core_type;
endpackage

// [tb/rss_supply_model.sv]
// supply comparator and reset pin model facing the sequencer
`timescale 1ns/1ns
module rss_supply_model
   import rss_pkg::*;
(
   // clock and target supply levels
   input  wire logic       pclk,
   input  wire logic [2:0] level_set,
   // reset pin from the sequencer
   input  wire logic       rst_pin_o,
   input  wire logic       rst_pin_oe,
   // comparator outputs and pin level
   output rss_supply_type  supply,
   output logic            rst_pin_lvl
);
   // comparators settle one cycle after the analog level moves
   always_ff @(posedge pclk) begin
      supply <= level_set;
   end
   // pin has a pull-up, so it is low only while driven
   assign rst_pin_lvl = rst_pin_oe ? rst_pin_o : 1'b1;
endmodule

// [tb/rss_reset_sequencer_tb_top.sv]
// self-checking bench of the reset source sequencer
`timescale 1ns/1ns
module rss_reset_sequencer_tb_top
   import rss_pkg::*;
;
   localparam int DLY = 20;
   logic           pclk = 1'b0;
   logic           presetn = 1'b0;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [7:0]     paddr = 8'h00;
   logic [31:0]    pwdata = 32'h00000000;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   logic [2:0]     lvl = 3'h0;
   logic           sleep_mode = 1'b0;
   logic           flash_op_req = 1'b0;
   rss_supply_type supply;
   logic           rst_pin_o;
   logic           rst_pin_oe;
   logic           rst_pin_lvl;
   rss_core_type   core;
   logic           warn_irq;
   logic [31:0]    rd;
   logic           er;
   int             bad_count = 0;
   int             tests_run = 0;
   int             cyc = 0;
   int             n;

   rss_reset_sequencer #(.POR_DELAY(DLY)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply(supply),
      .sleep_mode(sleep_mode), .flash_op_req(flash_op_req), .rst_pin_o(rst_pin_o),
      .rst_pin_oe(rst_pin_oe), .core(core), .warn_irq(warn_irq));
   rss_supply_model u_sup (.pclk(pclk), .level_set(lvl), .rst_pin_o(rst_pin_o),
      .rst_pin_oe(rst_pin_oe), .supply(supply), .rst_pin_lvl(rst_pin_lvl));

   // clock and hang guard
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end

   // word and bit comparisons
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   // one apb transfer, held until pready is seen high or 50 more cycles pass
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
         k++;
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // bounded wait for the core to run, cycle count left in n
   task automatic wait_run(input int lim);
      n = 0;
      @(negedge pclk);
      while (core.core_reset !== 1'b0 && n < lim) begin
         @(negedge pclk);
         n++;
      end
   endtask
   task automatic set_lvl(input logic [2:0] v, input int c);
      @(posedge pclk);
      lvl <= v;
      repeat (c) @(negedge pclk);
   endtask
   task automatic flash_pulse;
      @(posedge pclk);
      flash_op_req <= 1'b1;
      @(posedge pclk);
      flash_op_req <= 1'b0;
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chkb(rst_pin_lvl, 1'b0);
      chk({core.core_reset, core.sp_reset, core.clk_internal}, 32'h7);
      chkb(core.periph_reset, 1'b1);
      chk({core.port_latch, core.port_open_drain, core.weak_pullup}, 32'h3FF);
      chk({core.fetch_addr, core.wdt_enable, core.wdt_div}, 32'h1C);
      apb(1'b0, SUPPLY_MONITOR_CTRL_OFS, 32'h0);
      chk(rd & 32'h88, 32'h88);
      set_lvl(3'h7, 0);
      wait_run(DLY + 10);
      chkb(n >= DLY && n < DLY + 10, 1'b1);
      chkb(rst_pin_lvl, 1'b1);
      chkb(core.weak_pullup, 1'b1);
      chk({core.core_reset, core.periph_reset, core.sp_reset}, 32'h0);
      chkb(core.port_open_drain, 1'b0);
      apb(1'b0, RESET_CAUSE_REG_OFS, 32'h0);
      chkb(rd[POR_FLAG_BIT], 1'b1);
      apb(1'b0, SEQ_STATUS_OFS, 32'h0);
      chk(rd & 32'h1F, 32'h10);
      $display("test power_on finished");
      set_lvl(3'h6, 3);
      chkb(warn_irq, 1'b1);
      apb(1'b0, SUPPLY_MONITOR_CTRL_OFS, 32'h0);
      chkb(rd[WARN_OK_BIT], 1'b0);
      apb(1'b1, SUPPLY_MONITOR_CTRL_OFS, 32'h80);
      set_lvl(3'h6, 2);
      chkb(warn_irq, 1'b0);
      set_lvl(3'h4, 3);
      chkb(rst_pin_lvl, 1'b0);
      apb(1'b0, SEQ_STATUS_OFS, 32'h0);
      chk(rd & 32'h1F, 32'h04);
      set_lvl(3'h7, 0);
      wait_run(DLY);
      chkb(n < DLY, 1'b1);
      apb(1'b0, RESET_CAUSE_REG_OFS, 32'h0);
      chkb(rd[POR_FLAG_BIT], 1'b1);
      apb(1'b0, SUPPLY_MONITOR_CTRL_OFS, 32'h0);
      chk(rd & 32'h88, 32'h88);
      sleep_mode <= 1'b1;
      set_lvl(3'h4, 4);
      chkb(core.core_reset, 1'b0);
      set_lvl(3'h7, 1);
      @(posedge pclk);
      sleep_mode <= 1'b0;
      repeat (3) @(negedge pclk);
      chkb(core.core_reset, 1'b0);
      apb(1'b0, SUPPLY_MONITOR_CTRL_OFS, 32'h0);
      chkb(rd[MON_EN_BIT], 1'b1);
      $display("test power_fail finished");
      apb(1'b1, SUPPLY_MONITOR_CTRL_OFS, 32'h08);
      apb(1'b1, RESET_CAUSE_REG_OFS, 32'h00);
      apb(1'b1, RESET_CAUSE_REG_OFS, 32'h10);
      wait_run(10);
      apb(1'b0, RESET_CAUSE_REG_OFS, 32'h0);
      chk(rd & 32'h12, 32'h10);
      apb(1'b0, SUPPLY_MONITOR_CTRL_OFS, 32'h0);
      chkb(rd[MON_EN_BIT], 1'b0);
      set_lvl(3'h4, 4);
      chkb(core.core_reset, 1'b0);
      set_lvl(3'h7, 1);
      flash_pulse();
      wait_run(10);
      apb(1'b0, RESET_CAUSE_REG_OFS, 32'h0);
      chk(rd & 32'h42, 32'h40);
      apb(1'b1, SUPPLY_MONITOR_CTRL_OFS, 32'h88);
      apb(1'b1, RESET_CAUSE_REG_OFS, 32'h02);
      set_lvl(3'h4, 3);
      chkb(rst_pin_lvl, 1'b0);
      set_lvl(3'h7, 0);
      wait_run(DLY);
      flash_pulse();
      repeat (2) @(negedge pclk);
      chkb(core.core_reset, 1'b0);
      $display("test soft_flash finished");
      apb(1'b1, POWER_UNIT_MODE_REG_OFS, 32'h20);
      apb(1'b0, POWER_UNIT_MODE_REG_OFS, 32'h0);
      chkb(rd[BAT_DIS_BIT], 1'b1);
      apb(1'b1, RESET_CAUSE_REG_OFS, 32'h12);
      wait_run(DLY + 20);
      chkb(n >= DLY, 1'b1);
      apb(1'b0, POWER_UNIT_MODE_REG_OFS, 32'h0);
      chkb(rd[BAT_DIS_BIT], 1'b0);
      apb(1'b0, RESET_CAUSE_REG_OFS, 32'h0);
      chkb(rd[POR_FLAG_BIT], 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      $display("test battery_disable finished");
      close_out();
   end
endmodule
